// File: ifd_core.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_core #(
  parameter int STORE_CYCLES = ifd_pkg::STORE_CYCLES,
  parameter bit LARGE_STORE = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Storage port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [14:0] mem_addr_o,
  output logic [29:0] mem_wdata_o,
  input wire logic [29:0] mem_rdata_i,
  // Control
  input wire logic run_i,
  input wire logic skip_cond_i,
  input wire logic jump_i,
  input wire logic [14:0] jump_addr_i,
  input wire logic idx_we_i,
  input wire logic [2:0] idx_sel_i,
  input wire logic [14:0] idx_data_i,
  // Channels
  input wire logic [13:0] chan_req_i,
  input wire logic [13:0] chan_half_i,
  input wire logic [29:0] chan_data_i,
  output logic [13:0] chan_ack_o,
  output logic [29:0] chan_word_o,
  // Decoded fields
  output logic [5:0] opcode_o,
  output logic [2:0] skip_sel_o,
  output logic [2:0] opsel_o,
  output logic [2:0] index_sel_o,
  output logic [14:0] addr_field_o,
  output logic [14:0] eff_addr_o,
  output logic is_add_o,
  output logic addr_fault_o,
  output logic addr_reserved_o,
  output logic [29:0] operand_o,
  output logic operand_neg_o,
  output logic [14:0] pc_o,
  output logic decode_valid_o
);
  // ----------------------------------------------------------------
  // Index registers
  // ----------------------------------------------------------------
  // Seven index registers
  logic [14:0] idx_reg [1:7];
  logic [14:0] idx_next [1:7];
  genvar g;
  generate
    for (g = 1; g <= ifd_pkg::NUM_INDEX; g++) begin : g_idx
      always_comb begin
        idx_next[g] = idx_reg[g];
        if (idx_we_i && idx_sel_i == 3'(g)) begin
          idx_next[g] = idx_data_i;
        end
      end
      always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
          idx_reg[g] <= ifd_pkg::INDEX_RESET;
        end else begin
          idx_reg[g] <= idx_next[g];
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  ifd_pkg::ifd_state_type state_reg, state_next;
  logic [14:0] pc_reg, pc_next;
  logic [29:0] instr_reg, instr_next;
  logic [14:0] eff_reg, eff_next;
  logic [29:0] oper_reg, oper_next;
  logic valid_reg, valid_next;
  logic [11:0] wait_reg, wait_next;
  logic [14:0] idx_val;
  logic [14:0] addr_max;
  logic add_done;
  ifd_add_if add_bus ();

  ifd_index_adder u_adder (
    .a(add_bus)
  );

  assign addr_max = LARGE_STORE ? ifd_pkg::ADDR_MAX_LARGE : ifd_pkg::ADDR_MAX_SMALL;
  assign idx_val = (instr_reg[ifd_pkg::B_HI:ifd_pkg::B_LO] == 3'h0) ? 15'h0000 :
    idx_reg[instr_reg[ifd_pkg::B_HI:ifd_pkg::B_LO]];
  assign add_bus.field = instr_reg[ifd_pkg::Y_HI:ifd_pkg::Y_LO];
  assign add_bus.index = idx_val;
  assign add_done = (wait_reg == 12'(STORE_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    instr_next = instr_reg;
    eff_next = eff_reg;
    oper_next = oper_reg;
    valid_next = 1'b0;
    wait_next = 12'h000;
    case (state_reg)
      ifd_pkg::ST_IDLE: begin
        if (run_i) begin
          state_next = ifd_pkg::ST_FETCH;
        end
      end
      ifd_pkg::ST_FETCH: begin
        wait_next = wait_reg + 12'h001;
        if (add_done) begin
          instr_next = mem_rdata_i;
          wait_next = 12'h000;
          state_next = ifd_pkg::ST_DECODE;
        end
      end
      ifd_pkg::ST_DECODE: begin
        eff_next = add_bus.sum;
        if (instr_reg[ifd_pkg::K_HI:ifd_pkg::K_LO] == ifd_pkg::OPSEL_IMM) begin
          oper_next = {15'h0000, instr_reg[ifd_pkg::Y_HI:ifd_pkg::Y_LO]};
          state_next = ifd_pkg::ST_IDLE;
          valid_next = 1'b1;
        end else begin
          state_next = ifd_pkg::ST_OPER;
        end
      end
      ifd_pkg::ST_OPER: begin
        wait_next = wait_reg + 12'h001;
        if (add_done) begin
          wait_next = 12'h000;
          case (instr_reg[ifd_pkg::K_HI:ifd_pkg::K_LO])
            ifd_pkg::OPSEL_UPPER: oper_next = {15'h0000, mem_rdata_i[29:15]};
            ifd_pkg::OPSEL_LOWER: oper_next = {15'h0000, mem_rdata_i[14:0]};
            default: oper_next = mem_rdata_i;
          endcase
          valid_next = 1'b1;
          state_next = ifd_pkg::ST_IDLE;
        end
      end
      default: state_next = ifd_pkg::ST_IDLE;
    endcase
    if (valid_next) begin
      if (jump_i) begin
        pc_next = jump_addr_i;
      end else if (skip_cond_i && instr_reg[ifd_pkg::J_HI:ifd_pkg::J_LO] != 3'h0) begin
        pc_next = pc_reg + 15'h0002;
      end else begin
        pc_next = pc_reg + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_reg <= ifd_pkg::ST_IDLE;
      pc_reg <= ifd_pkg::PC_RESET;
      instr_reg <= 30'h00000000;
      eff_reg <= 15'h0000;
      oper_reg <= 30'h00000000;
      valid_reg <= 1'b0;
      wait_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      instr_reg <= instr_next;
      eff_reg <= eff_next;
      oper_reg <= oper_next;
      valid_reg <= valid_next;
      wait_reg <= wait_next;
    end
  end
  // ----------------------------------------------------------------
  // Registered flags
  // ----------------------------------------------------------------
  // Flags load with the registers they describe, so no flag compare drives a pin
  logic fault_reg, fault_next;
  logic resv_reg, resv_next;
  logic add_reg, add_next;
  always_comb begin
    fault_next = eff_next > addr_max;
    resv_next = eff_next <= ifd_pkg::RESERVED_TOP;
    add_next = instr_next[ifd_pkg::F_HI:ifd_pkg::F_LO] == ifd_pkg::OP_ADD;
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      fault_reg <= 1'b0;
      resv_reg <= 1'b0;
      add_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      resv_reg <= resv_next;
      add_reg <= add_next;
    end
  end
  // ----------------------------------------------------------------
  // Storage address
  // ----------------------------------------------------------------
  // Loaded ahead of the access so storage sees a settled address
  logic [14:0] maddr_reg, maddr_next;
  always_comb begin
    maddr_next = pc_next;
    if (state_next == ifd_pkg::ST_OPER) begin
      maddr_next = eff_next;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      maddr_reg <= ifd_pkg::PC_RESET;
    end else begin
      maddr_reg <= maddr_next;
    end
  end
  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Lowest channel wins; the sequencer never waits on a channel
  logic [13:0] ack_reg, ack_next;
  logic [29:0] cword_reg, cword_next;
  always_comb begin
    ack_next = 14'h0000;
    cword_next = cword_reg;
    for (int i = ifd_pkg::IO_CHANNELS - 1; i >= 0; i--) begin
      if (chan_req_i[i]) begin
        ack_next = 14'h0001 << i;
        cword_next = chan_half_i[i] ? {15'h0000, chan_data_i[14:0]} : chan_data_i;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_reg <= 14'h0000;
      cword_reg <= 30'h00000000;
    end else begin
      ack_reg <= ack_next;
      cword_reg <= cword_next;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_req_o = (state_reg == ifd_pkg::ST_FETCH) || (state_reg == ifd_pkg::ST_OPER);
  assign mem_we_o = 1'b0;
  assign mem_addr_o = maddr_reg;
  assign mem_wdata_o = 30'h00000000;
  assign chan_ack_o = ack_reg;
  assign chan_word_o = cword_reg;
  assign opcode_o = instr_reg[ifd_pkg::F_HI:ifd_pkg::F_LO];
  assign is_add_o = add_reg;
  assign skip_sel_o = instr_reg[ifd_pkg::J_HI:ifd_pkg::J_LO];
  assign opsel_o = instr_reg[ifd_pkg::K_HI:ifd_pkg::K_LO];
  assign index_sel_o = instr_reg[ifd_pkg::B_HI:ifd_pkg::B_LO];
  assign addr_field_o = instr_reg[ifd_pkg::Y_HI:ifd_pkg::Y_LO];
  assign eff_addr_o = eff_reg;
  assign addr_fault_o = fault_reg;
  assign addr_reserved_o = resv_reg;
  assign operand_o = oper_reg;
  assign operand_neg_o = oper_reg[ifd_pkg::SIGN_POS];
  assign pc_o = pc_reg;
  assign decode_valid_o = valid_reg;
endmodule
`default_nettype wire

// File: ifd_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_core_chk #(
  parameter int STORE_CYCLES = ifd_pkg::STORE_CYCLES,
  parameter bit LARGE_STORE = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Watched ports
  input wire logic mem_req_o,
  input wire logic [14:0] mem_addr_o,
  input wire logic [13:0] chan_req_i,
  input wire logic [13:0] chan_ack_o,
  input wire logic [5:0] opcode_o,
  input wire logic [2:0] opsel_o,
  input wire logic [2:0] index_sel_o,
  input wire logic [14:0] addr_field_o,
  input wire logic [14:0] eff_addr_o,
  input wire logic is_add_o,
  input wire logic addr_fault_o,
  input wire logic addr_reserved_o,
  input wire logic [29:0] operand_o,
  input wire logic operand_neg_o,
  input wire logic decode_valid_o
);
  localparam logic [14:0] LIM = LARGE_STORE ? ifd_pkg::ADDR_MAX_LARGE : ifd_pkg::ADDR_MAX_SMALL;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Length of each storage access, restarted whenever the request drops
  logic [11:0] acc_cnt_reg;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !mem_req_o) begin
      acc_cnt_reg <= 12'h000;
    end else begin
      acc_cnt_reg <= acc_cnt_reg + 12'h001;
    end
  end
  a_access_time: assert property ($fell(mem_req_o) |-> acc_cnt_reg == 12'(STORE_CYCLES))
    else $error("storage access length wrong");
  a_valid_one_cycle: assert property (decode_valid_o |=> !decode_valid_o)
    else $error("valid pulse too long");
  a_add_decode: assert property (decode_valid_o |-> is_add_o == (opcode_o == 6'h10))
    else $error("add decode wrong");
  a_sign_bit: assert property (decode_valid_o |-> operand_neg_o == operand_o[29])
    else $error("sign flag wrong");
  a_index_zero: assert property (decode_valid_o && index_sel_o == 3'h0 |-> eff_addr_o == addr_field_o)
    else $error("index zero altered address");
  a_zero_result: assert property (decode_valid_o && eff_addr_o == 15'h0 |-> addr_field_o == 15'h0)
    else $error("zero address from nonzero field");
  a_reserved_flag: assert property (decode_valid_o |-> addr_reserved_o == (eff_addr_o <= 15'h005e))
    else $error("reserved flag wrong");
  a_fault_flag: assert property (decode_valid_o |-> addr_fault_o == (eff_addr_o > LIM))
    else $error("fault flag wrong");
  a_operand_addr: assert property (decode_valid_o && opsel_o != 3'h4 |-> $past(mem_req_o) && $past(mem_addr_o) == eff_addr_o)
    else $error("operand read address wrong");
  a_ack_onehot: assert property ($onehot0(chan_ack_o))
    else $error("several channel grants");
  a_ack_has_req: assert property (chan_ack_o != 14'h0 |-> (chan_ack_o & $past(chan_req_i)) != 14'h0)
    else $error("grant without request");
  c_add: cover property (decode_valid_o && is_add_o);
  c_fault: cover property (decode_valid_o && addr_fault_o);
  c_chan: cover property (chan_ack_o != 14'h0);
endmodule
bind ifd_core ifd_core_chk #(.STORE_CYCLES(STORE_CYCLES), .LARGE_STORE(LARGE_STORE)) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
  .chan_req_i(chan_req_i), .chan_ack_o(chan_ack_o), .opcode_o(opcode_o), .opsel_o(opsel_o),
  .index_sel_o(index_sel_o), .addr_field_o(addr_field_o), .eff_addr_o(eff_addr_o),
  .is_add_o(is_add_o), .addr_fault_o(addr_fault_o), .addr_reserved_o(addr_reserved_o),
  .operand_o(operand_o), .operand_neg_o(operand_neg_o), .decode_valid_o(decode_valid_o)
);
`default_nettype wire

// File: ifd_if.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// Index adder request and answer
// ------------------------------------------------------------------
interface ifd_add_if;
  logic [14:0] field;
  logic [14:0] index;
  logic [14:0] sum;
  modport req (output field, output index, input sum);
  modport add (input field, input index, output sum);
endinterface
`default_nettype wire

// File: ifd_index_adder.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_index_adder (
  ifd_add_if.add a
);
  logic [15:0] raw;
  logic [15:0] wrapped;
  // End-around carry
  // Carry folds back into bit 0; zero only from zero plus zero
  always_comb begin
    raw = {1'b0, a.field} + {1'b0, a.index};
    wrapped = {1'b0, raw[14:0]} + {15'h0000, raw[15]};
  end
  assign a.sum = wrapped[14:0];
endmodule
`default_nettype wire

// File: ifd_pkg.sv
package ifd_pkg;
  // ----------------------------------------------------------------
  // Word and field layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 30;
  localparam int ADDR_W = 15;
  localparam int SIGN_POS = 29;
  localparam int F_HI = 29;
  localparam int F_LO = 24;
  localparam int J_HI = 23;
  localparam int J_LO = 21;
  localparam int K_HI = 20;
  localparam int K_LO = 18;
  localparam int B_HI = 17;
  localparam int B_LO = 15;
  localparam int Y_HI = 14;
  localparam int Y_LO = 0;
  localparam int NUM_INDEX = 7;
  // ----------------------------------------------------------------
  // Address limits and reset values
  // ----------------------------------------------------------------
  localparam logic [14:0] ADDR_MAX_SMALL = 15'h3fff;
  localparam logic [14:0] ADDR_MAX_LARGE = 15'h7fff;
  localparam logic [14:0] RESERVED_TOP = 15'h005e;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [14:0] INDEX_RESET = 15'h0000;
  localparam logic [5:0] OP_ADD = 6'h10;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int STORE_US = 6;
  localparam int STORE_CYCLES = STORE_US * CLK_MHZ;
  localparam int IO_CHANNELS = 14;
  localparam int IO_COMPUTER = 2;
  localparam int IO_PERIPH = 12;
  // ----------------------------------------------------------------
  // Operand select and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OPSEL_UPPER = 3'h1,
    OPSEL_LOWER = 3'h2,
    OPSEL_FULL = 3'h3,
    OPSEL_IMM = 3'h4
  } ifd_opsel_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FETCH = 4'h2,
    ST_DECODE = 4'h4,
    ST_OPER = 4'h8
  } ifd_state_type;
endpackage

// File: ifd_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_store_model (
  // Clock
  input wire logic clk_i,
  // Storage port
  input wire logic mem_req_i,
  input wire logic [14:0] mem_addr_i,
  output logic [29:0] mem_rdata_o
);
  logic [29:0] mem [0:32767];
  logic [29:0] last_reg;
  // Cleared so untouched words read as zero, not unknown
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 30'h00000000;
    end
  end
  assign mem_rdata_o = mem_req_i ? mem[mem_addr_i] : ~last_reg;
  // Idle bus toggles so a stale word never passes
  always_ff @(posedge clk_i) begin
    last_reg <= mem_rdata_o;
  end
endmodule
`default_nettype wire

// File: instruction_field_decode_index_test.sv
`timescale 1ns/1ps
`default_nettype none
module instruction_field_decode_index_test;
  logic clk_i = 0, reset_n_i = 0, run_i = 0, skip_cond_i = 0, jump_i = 0, idx_we_i = 0, mem_req_o;
  logic [14:0] jump_addr_i = 0, idx_data_i = 0, mem_addr_o, addr_field_o, eff_addr_o, pc_o;
  logic [2:0] idx_sel_i = 0, skip_sel_o, opsel_o, index_sel_o;
  logic [13:0] chan_req_i = 0, chan_half_i = 0, chan_ack_o;
  logic [29:0] chan_data_i = 0, mem_rdata_i, chan_word_o, operand_o;
  logic [5:0] opcode_o;
  logic is_add_o, addr_fault_o, addr_reserved_o, operand_neg_o, decode_valid_o;
  int err_total = 0, total_checks = 0;
  always #2 clk_i = ~clk_i;
  ifd_store_model u_mem (.clk_i(clk_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .mem_rdata_o(mem_rdata_i));
  // Short access count keeps the run brief; small store exercises the fault flag
  ifd_core #(.STORE_CYCLES(4), .LARGE_STORE(1'b0)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .mem_req_o(mem_req_o), .mem_we_o(), .mem_addr_o(mem_addr_o), .mem_wdata_o(),
    .mem_rdata_i(mem_rdata_i), .run_i(run_i), .skip_cond_i(skip_cond_i), .jump_i(jump_i),
    .jump_addr_i(jump_addr_i), .idx_we_i(idx_we_i), .idx_sel_i(idx_sel_i),
    .idx_data_i(idx_data_i), .chan_req_i(chan_req_i), .chan_half_i(chan_half_i),
    .chan_data_i(chan_data_i), .chan_ack_o(chan_ack_o), .chan_word_o(chan_word_o),
    .opcode_o(opcode_o), .skip_sel_o(skip_sel_o), .opsel_o(opsel_o),
    .index_sel_o(index_sel_o), .addr_field_o(addr_field_o), .eff_addr_o(eff_addr_o),
    .is_add_o(is_add_o), .addr_fault_o(addr_fault_o), .addr_reserved_o(addr_reserved_o),
    .operand_o(operand_o), .operand_neg_o(operand_neg_o), .pc_o(pc_o),
    .decode_valid_o(decode_valid_o));
  task automatic check(input logic [29:0] seen, input logic [29:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [29:0] mk(logic [5:0] f, logic [2:0] j, k, b, logic [14:0] y);
    return {f, j, k, b, y};
  endfunction
  task automatic wr_idx(input logic [2:0] s, input logic [14:0] d);
    idx_we_i = 1;
    idx_sel_i = s;
    idx_data_i = d;
    @(posedge clk_i) #1;
    idx_we_i = 0;
  endtask
  // One instruction from the current counter; levels held until the pulse
  task automatic exec(input logic [29:0] ins, input logic sk, jp, input logic [14:0] ja);
    int n;
    n = 0;
    u_mem.mem[pc_o] = ins;
    skip_cond_i = sk;
    jump_i = jp;
    jump_addr_i = ja;
    run_i = 1;
    do begin
      @(posedge clk_i) #1;
      n++;
    end while (decode_valid_o !== 1'b1 && n < 40);
    run_i = 0;
    if (n >= 40) check(30'h0, 30'h1);
  endtask
  task automatic t_index();
    wr_idx(3'h2, 15'h002d);
    exec(mk(6'h10, 3'h5, 3'h3, 3'h2, 15'h0068), 0, 0, 0);
    check(30'(opcode_o), 30'h10);
    check(30'(is_add_o), 30'h1);
    check(30'(skip_sel_o), 30'h5);
    check(30'(opsel_o), 30'h3);
    check(30'(index_sel_o), 30'h2);
    check(30'(eff_addr_o), 30'h95);
    check(30'(addr_field_o), 30'h68);
    wr_idx(3'h0, 15'h1111);
    exec(mk(6'h01, 3'h0, 3'h4, 3'h0, 15'h7fff), 0, 0, 0);
    check(30'(eff_addr_o), 30'h7fff);
    wr_idx(3'h7, 15'h4000);
    exec(mk(6'h10, 3'h0, 3'h4, 3'h7, 15'h4000), 0, 0, 0);
    check(30'(eff_addr_o), 30'h1);
    wr_idx(3'h1, 15'h0001);
    exec(mk(6'h10, 3'h0, 3'h4, 3'h1, 15'h7ffe), 0, 0, 0);
    check(30'(eff_addr_o), 30'h7fff);
    $display("test index done");
  endtask
  task automatic t_operand();
    logic [29:0] w;
    w = 30'h2345_6789;
    u_mem.mem[15'h0100] = w;
    for (int k = 1; k <= 4; k++) begin
      exec(mk(6'h10, 3'h0, 3'(k), 3'h0, 15'h0100), 0, 0, 0);
      if (k == 1) check(operand_o, {15'h0000, w[29:15]});
      if (k == 2) check(operand_o, {15'h0000, w[14:0]});
      if (k == 3) check(operand_o, w);
      if (k == 3) check(30'(operand_neg_o), 30'h1);
      if (k == 4) check(operand_o, 30'h0100);
    end
    $display("test operand done");
  endtask
  task automatic t_limits();
    logic [14:0] ys [4] = '{15'h005e, 15'h005f, 15'h3fff, 15'h4000};
    for (int i = 0; i < 4; i++) begin
      exec(mk(6'h01, 3'h0, 3'h4, 3'h0, ys[i]), 0, 0, 0);
      check(30'(addr_reserved_o), 30'(i == 0));
      check(30'(addr_fault_o), 30'(i == 3));
    end
    $display("test limits done");
  endtask
  task automatic t_seq();
    logic [14:0] p;
    p = pc_o;
    exec(mk(6'h01, 3'h0, 3'h4, 3'h0, 15'h0), 1, 0, 0);
    check(30'(pc_o), 30'(p + 15'h1));
    exec(mk(6'h01, 3'h1, 3'h4, 3'h0, 15'h0), 1, 0, 0);
    check(30'(pc_o), 30'(p + 15'h3));
    exec(mk(6'h01, 3'h1, 3'h4, 3'h0, 15'h0), 0, 1, 15'h0200);
    check(30'(pc_o), 30'h200);
    $display("test sequence done");
  endtask
  task automatic t_chan();
    chan_data_i = 30'h2aaa_d555;
    chan_req_i = 14'h0006;
    chan_half_i = 14'h0002;
    repeat (2) @(posedge clk_i) #1;
    check(30'(chan_ack_o), 30'h2);
    check(chan_word_o, 30'h5555);
    chan_req_i = 14'h2000;
    chan_half_i = 14'h0;
    repeat (2) @(posedge clk_i) #1;
    check(30'(chan_ack_o), 30'h2000);
    check(chan_word_o, 30'h2aaa_d555);
    chan_req_i = 14'h0;
    $display("test channel done");
  endtask
  initial begin
    repeat (2) @(posedge clk_i) #1;
    reset_n_i = 1;
    t_index();
    t_operand();
    t_limits();
    t_seq();
    t_chan();
    report_and_stop();
  end
  initial begin
    #40000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
